// file: fro_pkg.sv
// package for the file-register alu and bit-operation executor
// assumes a 14-bit instruction word and an 8-bit data path
// Functional notes
// - opcode 0111 adds w to file, writes dest, updates carry, digit carry, zero.
// - destination bit 0 writes w; 1 writes back into the file register.
// - opcode 0101 ands w with file, writes dest, updates zero only.
// - bit clear encoding 01 00bb clears selected bit, flags unchanged.
// - bit test encoding 01 10bb skips next instruction when bit is zero.
// - taken skip discards prefetched instruction, runs a nop, two cycles total.
package fro_pkg;
  localparam logic [1:0] FRO_GRP_BYTE  = 2'h0;
  localparam logic [1:0] FRO_GRP_BIT   = 2'h1;
  localparam logic [3:0] FRO_OP_ADD    = 4'h7;
  localparam logic [3:0] FRO_OP_AND    = 4'h5;
  localparam logic [1:0] FRO_BOP_CLR   = 2'h0;
  localparam logic [1:0] FRO_BOP_SET   = 2'h1;
  localparam logic [1:0] FRO_BOP_TSTC  = 2'h2;
  localparam int         FRO_GRP_MSB   = 13;
  localparam int         FRO_OP_LSB    = 8;
  localparam int         FRO_BOP_LSB   = 10;
  localparam int         FRO_BIT_LSB   = 7;
  localparam int         FRO_DEST_POS  = 7;
  localparam logic [7:0] FRO_W_RST     = 8'h00;
  localparam logic [6:0] FRO_ADDR_RST  = 7'h00;
  localparam logic [7:0] FRO_DATA_RST  = 8'h00;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } fro_fwr_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } fro_flags_t;

  typedef enum logic [0:0] {
    FRO_EXEC = 1'b0,
    FRO_NOP  = 1'b1
  } fro_state_t;
endpackage

// file: fro_exec.sv
// executor for add, and, bit clear, bit set and bit test skip if clear
// assumes the file register is read combinationally via file_rdata for file_addr
// one instruction is presented per cycle while instr_valid is high
`timescale 1ns/1ps
module fro_exec (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               instr_valid,
  input  wire logic [13:0]        instr,
  output logic      [6:0]         file_addr,
  input  wire logic [7:0]         file_rdata,
  output fro_pkg::fro_fwr_t       file_wr,
  output logic      [7:0]         wreg,
  output fro_pkg::fro_flags_t     flags,
  output logic      [2:0]         flags_we,
  output logic                    skip_nop,
  output logic                    busy
);
  import fro_pkg::*;

  fro_state_t   state_q, state_d;
  logic [7:0]   w_q, w_d;
  fro_fwr_t     fwr_q, fwr_d;
  fro_flags_t   flg_q, flg_d;
  logic [2:0]   fwe_q, fwe_d;
  logic         nop_q, nop_d;
  logic [6:0]   faddr;
  logic [7:0]   res;
  logic [8:0]   sum;
  logic [4:0]   low_sum;
  logic [2:0]   bsel;
  logic         is_add, is_and, is_clr, is_set, is_tst, dest_f;

  assign faddr     = instr[6:0];
  assign file_addr = faddr;
  assign bsel      = instr[FRO_BIT_LSB +: 3];
  assign dest_f    = instr[FRO_DEST_POS];
  assign is_add = instr[FRO_GRP_MSB -: 2] == FRO_GRP_BYTE
               && instr[FRO_OP_LSB +: 4] == FRO_OP_ADD;
  assign is_and = instr[FRO_GRP_MSB -: 2] == FRO_GRP_BYTE
               && instr[FRO_OP_LSB +: 4] == FRO_OP_AND;
  assign is_clr = instr[FRO_GRP_MSB -: 2] == FRO_GRP_BIT
               && instr[FRO_BOP_LSB +: 2] == FRO_BOP_CLR;
  assign is_set = instr[FRO_GRP_MSB -: 2] == FRO_GRP_BIT
               && instr[FRO_BOP_LSB +: 2] == FRO_BOP_SET;
  assign is_tst = instr[FRO_GRP_MSB -: 2] == FRO_GRP_BIT
               && instr[FRO_BOP_LSB +: 2] == FRO_BOP_TSTC;
  assign sum     = {1'b0, w_q} + {1'b0, file_rdata};
  assign low_sum = {1'b0, w_q[3:0]} + {1'b0, file_rdata[3:0]};

  always_comb begin
    state_d = FRO_EXEC;
    w_d     = w_q;
    fwr_d   = '{we: 1'b0, addr: faddr, data: FRO_DATA_RST};
    flg_d   = flg_q;
    fwe_d   = 3'h0;
    nop_d   = 1'b0;
    res     = FRO_DATA_RST;
    case (state_q)
      FRO_NOP: begin
        // prefetched word is dropped here, nothing changes
        state_d = FRO_EXEC;
        nop_d   = 1'b1;
      end
      FRO_EXEC: begin
        if (instr_valid) begin
          if (is_add || is_and) begin
            res = is_add ? sum[7:0] : (w_q & file_rdata);
            if (dest_f) begin
              fwr_d = '{we: 1'b1, addr: faddr, data: res};
            end else begin
              w_d = res;
            end
            flg_d.z = (res == 8'h00);
            if (is_add) begin
              flg_d.c  = sum[8];
              flg_d.dc = low_sum[4];
              fwe_d    = 3'h7;
            end else begin
              fwe_d = 3'h1;
            end
          end else if (is_clr) begin
            res   = file_rdata & ~(8'h01 << bsel);
            fwr_d = '{we: 1'b1, addr: faddr, data: res};
          end else if (is_set) begin
            res   = file_rdata | (8'h01 << bsel);
            fwr_d = '{we: 1'b1, addr: faddr, data: res};
          end else if (is_tst && !file_rdata[bsel]) begin
            state_d = FRO_NOP;
          end
        end
      end
      default: state_d = FRO_EXEC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= FRO_EXEC;
      w_q     <= FRO_W_RST;
      fwr_q   <= '{we: 1'b0, addr: FRO_ADDR_RST, data: FRO_DATA_RST};
      flg_q   <= '{c: 1'b0, dc: 1'b0, z: 1'b0};
      fwe_q   <= 3'h0;
      nop_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      w_q     <= w_d;
      fwr_q   <= fwr_d;
      flg_q   <= flg_d;
      fwe_q   <= fwe_d;
      nop_q   <= nop_d;
    end
  end

  assign file_wr  = fwr_q;
  assign wreg     = w_q;
  assign flags    = flg_q;
  assign flags_we = fwe_q;
  assign skip_nop = nop_q;
  assign busy     = (state_q == FRO_NOP);

  // file_addr is the one combinational output: the read must see this cycle's operand
  sequence s_skip_taken;
    instr_valid && !busy && is_tst && !file_rdata[bsel];
  endsequence
  sequence s_nop_slot;
    busy ##1 skip_nop && !busy;
  endsequence
  sequence s_byte_op;
    instr_valid && !busy && (is_add || is_and);
  endsequence
  sequence s_bit_write;
    instr_valid && !busy && (is_clr || is_set);
  endsequence
  sequence s_idle;
    !instr_valid && !busy;
  endsequence

  AST_ADD_SUM: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_add |=> flags_we == 3'h7
    && flags.c == (({1'b0, $past(wreg)} + {1'b0, $past(file_rdata)}) > 9'h0FF))
    else $error("add carry wrong");
  AST_DEST_W: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && (is_add || is_and) && !dest_f |=> !file_wr.we)
    else $error("dest w wrote file");
  AST_DEST_F: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && (is_add || is_and) && dest_f |=> file_wr.we && $stable(wreg))
    else $error("dest f wrong");
  AST_AND_Z: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_and |=> flags_we == 3'h1 && $stable(flags.c)
    && $stable(flags.dc))
    else $error("and flags wrong");
  AST_CLR_BIT: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_clr |=> file_wr.we && !file_wr.data[$past(bsel)]
    && flags_we == 3'h0)
    else $error("bit clear wrong");
  AST_SET_BIT: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_set |=> file_wr.we && file_wr.data[$past(bsel)])
    else $error("bit set wrong");
  AST_SKIP: assert property (@(posedge clk) disable iff (!rstn)
    s_skip_taken |=> s_nop_slot)
    else $error("skip not taken");
  AST_NOP_QUIET: assert property (@(posedge clk) disable iff (!rstn)
    busy |=> !file_wr.we && flags_we == 3'h0 && $stable(wreg))
    else $error("nop slot changed state");
  AST_NO_SKIP: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_tst && file_rdata[bsel] |=> !busy)
    else $error("skip on set bit");

  // results rebuilt from last cycle's ports, not from the datapath nets
  AST_ADD_W: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_add && !dest_f
    |=> wreg == 8'($past(wreg) + $past(file_rdata)))
    else $error("add result in w wrong");
  AST_ADD_F: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_add && dest_f
    |=> file_wr.data == 8'($past(wreg) + $past(file_rdata)))
    else $error("add result in file wrong");
  AST_ADD_DC: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_add
    |=> flags.dc == (({1'b0, $past(wreg[3:0])} + {1'b0, $past(file_rdata[3:0])}) > 5'h0F))
    else $error("add digit carry wrong");
  AST_AND_W: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_and && !dest_f
    |=> wreg == ($past(wreg) & $past(file_rdata)))
    else $error("and result in w wrong");
  AST_AND_F: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_and && dest_f
    |=> file_wr.data == ($past(wreg) & $past(file_rdata)))
    else $error("and result in file wrong");
  AST_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    s_byte_op |=> flags.z == ((file_wr.we ? file_wr.data : wreg) == 8'h00))
    else $error("zero flag wrong");

  // bit operations: only the selected bit may move, flags and w stay put
  AST_WR_ADDR: assert property (@(posedge clk) disable iff (!rstn)
    s_bit_write |=> file_wr.we && file_wr.addr == $past(file_addr))
    else $error("bit write address wrong");
  AST_CLR_KEEP: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_clr
    |=> (file_wr.data | (8'h01 << $past(bsel)))
        == ($past(file_rdata) | (8'h01 << $past(bsel))))
    else $error("bit clear touched other bits");
  AST_SET_KEEP: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_set
    |=> (file_wr.data & ~(8'h01 << $past(bsel)))
        == ($past(file_rdata) & ~(8'h01 << $past(bsel))))
    else $error("bit set touched other bits");
  AST_BIT_FLAGS: assert property (@(posedge clk) disable iff (!rstn)
    s_bit_write |=> flags_we == 3'h0 && $stable(flags) && $stable(wreg))
    else $error("bit write changed flags or w");
  AST_TST_QUIET: assert property (@(posedge clk) disable iff (!rstn)
    instr_valid && !busy && is_tst
    |=> !file_wr.we && flags_we == 3'h0 && $stable(flags) && $stable(wreg))
    else $error("bit test changed state");

  // stall bookkeeping around a taken skip, then a check that idle cycles change nothing
  AST_BUSY_CAUSE: assert property (@(posedge clk) disable iff (!rstn)
    busy |-> $past(instr_valid && !busy && is_tst && !file_rdata[bsel]))
    else $error("stall without taken skip");
  AST_BUSY_ONE: assert property (@(posedge clk) disable iff (!rstn)
    busy |=> !busy)
    else $error("stall longer than one cycle");
  AST_NOP_AFTER: assert property (@(posedge clk) disable iff (!rstn)
    skip_nop |-> !busy && $past(busy))
    else $error("nop pulse without stall");
  AST_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    s_idle |=> !file_wr.we && flags_we == 3'h0 && !skip_nop && $stable(wreg))
    else $error("idle cycle changed state");
endmodule

// file: fro_exec_tb.sv
// testbench for fro_exec: table of byte and bit operations, then skip and reset
// assumes the bench stands in for the register file on file_rdata
`timescale 1ns/1ps
module fro_exec_tb;
  import fro_pkg::*;
  typedef struct packed {
    logic [13:0] ins;
    logic [7:0]  rd;
    logic [8:0]  ctl;
    logic [7:0]  wd;
    logic [7:0]  wr;
  } fro_row_t;
  logic        clk = 1'b0;
  logic        rstn;
  logic        instr_valid;
  logic [13:0] instr;
  logic [7:0]  file_rdata;
  logic [6:0]  file_addr;
  logic [7:0]  wreg;
  logic [2:0]  flags_we;
  logic        skip_nop;
  logic        busy;
  fro_fwr_t    file_wr;
  fro_flags_t  flags;
  int          n_mismatch = 0;
  int          tests_run = 0;
  fro_row_t    rows [11];
  fro_exec uut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_wr(file_wr), .wreg(wreg),
    .flags(flags), .flags_we(flags_we), .skip_nop(skip_nop), .busy(busy));
  initial begin
    forever #10 clk = ~clk;
  end
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  // ctl bundle: {we, flags_we, c, dc, z, skip_nop, busy}
  task chk_ctl(input logic [8:0] exp);
    tests_run++;
    if ({file_wr.we, flags_we, flags, skip_nop, busy} !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t control %h expected %h", $time,
               {file_wr.we, flags_we, flags, skip_nop, busy}, exp);
    end
  endtask
  task complete_run;
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task drv(input logic [13:0] i, input logic [7:0] d);
    instr = i;
    file_rdata = d;
    instr_valid = 1'b1;
    // file_addr follows instr combinationally: let it settle before comparing
    #1;
  endtask
  task stp;
    @(posedge clk);
    #1;
  endtask
  initial begin
    #(20 * 200);
    n_mismatch++;
    complete_run;
  end
  initial begin
    rows = '{'{14'h0710, 8'h17, 9'h0E0, 8'h00, 8'h17}, '{14'h0784, 8'hC2, 9'h1E0, 8'hD9, 8'h17},
             '{14'h0710, 8'hE9, 9'h0FC, 8'h00, 8'h00}, '{14'h0710, 8'h17, 9'h0E0, 8'h00, 8'h17},
             '{14'h0784, 8'h09, 9'h1E8, 8'h20, 8'h17},
             '{14'h0584, 8'hC2, 9'h128, 8'h02, 8'h17}, '{14'h0510, 8'h40, 9'h02C, 8'h00, 8'h00},
             '{14'h1385, 8'hC7, 9'h10C, 8'h47, 8'h00}, '{14'h1785, 8'h0A, 9'h10C, 8'h8A, 8'h00},
             '{14'h1885, 8'h02, 9'h00C, 8'h00, 8'h00}, '{14'h1C85, 8'h00, 9'h00C, 8'h00, 8'h00}};
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr = 14'h0000;
    file_rdata = 8'h00;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    foreach (rows[i]) begin
      drv(rows[i].ins, rows[i].rd);
      chk_byte({1'b0, file_addr}, {1'b0, rows[i].ins[6:0]});
      stp;
      chk_ctl(rows[i].ctl);
      chk_byte(wreg, rows[i].wr);
      if (rows[i].ctl[8]) chk_byte(file_wr.data, rows[i].wd);
      if (rows[i].ctl[8]) chk_byte({1'b0, file_wr.addr}, 8'h04 + {7'h00, rows[i].ins[12]});
      $display("row %0d done", i);
    end
    drv(14'h1885, 8'h00);
    stp;
    chk_ctl(9'h00D);
    drv(14'h0784, 8'hFF);
    stp;
    chk_ctl(9'h00E);
    drv(14'h0710, 8'h80);
    stp;
    chk_byte(wreg, 8'h80);
    chk_ctl(9'h0E0);
    $display("skip test done");
    instr_valid = 1'b0;
    file_rdata = 8'h81;
    stp;
    chk_ctl(9'h000);
    chk_byte(wreg, 8'h80);
    drv(14'h0710, 8'h81);
    stp;
    chk_ctl(9'h0F0);
    chk_byte(wreg, 8'h01);
    $display("idle test done");
    instr_valid = 1'b0;
    rstn = 1'b0;
    stp;
    rstn = 1'b1;
    chk_ctl(9'h000);
    chk_byte(wreg, 8'h00);
    $display("reset test done");
    complete_run;
  end
endmodule
